// File: include/cgs_consts.vh
// What this block does
// - Key A5h with 03h opens clock writes and sets the low-power flag, which gates no register; 00h clears both.
// - Divider field 0001b divides by 2, 0010b by 4, for every clock.
// - A pin-stop bit at 1 disables that clock pin and holds it high.
// - Source select 000b main, 001b fast internal, 100b PLL.
// - Bus pin halving bit at 0 drives the bus clock pin undivided.
// - Fast oscillator stop bit: 0 runs while powered, 1 halts.
// - Fast oscillator power-off bit at 1 removes its supply.
// - Main wait code 01100b means 65536 oscillator cycles.
// - Main oscillator stop bit at 0 lets the oscillator run.
// - PLL wait code 01010b means 131072 cycles.
// - PLL input divider 00b passes input; multiplier 001111b gives times 16.
// - PLL stop bit at 0 lets the PLL operate.
// - Slow oscillator stop bit at 1 stops the sub-clock oscillator.
// - Calendar oscillator enable at 0 also stops the sub-clock oscillator.
// - Calendar source bit picks main clock at 1, sub-clock at 0.
// - Calendar start bit at 0 halts prescaler and counters.
// - Writing calendar reset bit 1 resets prescaler and targets; software waits.
// - Writing 00h to calendar interrupt control disables all three requests.
// - Slow drive field 001b is low drive, 110b standard drive.
`ifndef CGS_CONSTS_VH
`define CGS_CONSTS_VH
`define CGS_A_PROT 8'h00
`define CGS_A_SDIV 8'h04
`define CGS_A_SDIV2 8'h08
`define CGS_A_BPIN 8'h0c
`define CGS_A_SSEL 8'h10
`define CGS_A_FOSC 8'h14
`define CGS_A_FPWR 8'h18
`define CGS_A_MWAIT 8'h1c
`define CGS_A_MOSC 8'h20
`define CGS_A_PWAIT 8'h24
`define CGS_A_PCFG 8'h28
`define CGS_A_PRUN 8'h2c
`define CGS_A_SOSC 8'h30
`define CGS_A_CIRQ 8'h34
`define CGS_A_CRUN 8'h38
`define CGS_A_COSC 8'h3c
`define CGS_A_CSRC 8'h40
`define CGS_A_STAT 8'h44
`define CGS_KEY 8'ha5
`define CGS_PROT_CG 0
`define CGS_PROT_LP 1
`define CGS_SDIV_RST 32'h00000000
`define CGS_SDIV2_RST 16'h0000
`define CGS_SDIV_PERIPH_B_DIVIDER 8
`define CGS_SDIV_PERIPH_A_DIVIDER 12
`define CGS_SDIV_BCK 16
`define CGS_SDIV_SDRAM_CLOCK_PIN_STOP 22
`define CGS_SDIV_BUS_CLOCK_PIN_STOP 23
`define CGS_SDIV_ICK 24
`define CGS_SDIV_FCK 28
`define CGS_SDIV2_IEB 0
`define CGS_SSEL_LSB 8
`define CGS_SRC_MAIN 3'h0
`define CGS_SRC_FAST 3'h1
`define CGS_SRC_PLL 3'h4
`define CGS_WAIT_MAIN_CODE 5'h0c
`define CGS_WAIT_MAIN_CYC 18'h10000
`define CGS_WAIT_PLL_CODE 5'h0a
`define CGS_WAIT_PLL_CYC 18'h20000
`define CGS_WAIT_PLL_BASE 18'h00080
`define CGS_PCFG_MUL_LSB 8
`define CGS_RESET_CYC 4'h6
`define CGS_CRUN_START 0
`define CGS_CRUN_RESET 1
`define CGS_COSC_EN 0
`define CGS_COSC_DRV 1
`define CGS_DRV_LOW 3'h1
`define CGS_DRV_STD 3'h6
`endif

// File: rtl/cgs_top.v
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "cgs_consts.vh"
module cgs_top (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg [3:0] core_clock_div,
  output reg [3:0] periph_clock_a_div,
  output reg [3:0] periph_clock_b_div,
  output reg [3:0] bus_clock_div,
  output reg [3:0] flash_if_clock_div,
  output reg [3:0] serial_bus_clock_div,
  output reg sdram_clock_pin_en,
  output reg bus_clock_pin_en,
  output reg bus_clock_pin_halved,
  output reg [2:0] system_source_select,
  output reg fast_osc_run,
  output reg fast_osc_supply,
  output reg main_osc_run,
  output reg pll_run,
  output reg [1:0] pll_input_divider,
  output reg [5:0] pll_multiplier,
  output reg [17:0] main_wait_cycles,
  output reg [17:0] pll_wait_cycles,
  output reg slow_osc_run,
  output reg [2:0] slow_osc_drive,
  output reg calendar_main_source,
  output reg calendar_count_en,
  output reg calendar_reset_pulse,
  output reg alarm_irq_enable,
  output reg carry_irq_enable,
  output reg periodic_irq_enable
);

  reg clockgen_write_enable_q;
  reg lowpower_write_enable_q;
  reg [31:0] sdiv_q;
  reg [15:0] sdiv2_q;
  reg [7:0] bpin_q;
  reg [15:0] ssel_q;
  reg [7:0] fosc_q;
  reg [7:0] fpwr_q;
  reg [7:0] mwait_q;
  reg [7:0] mosc_q;
  reg [7:0] pwait_q;
  reg [15:0] pcfg_q;
  reg [7:0] prun_q;
  reg [7:0] sosc_q;
  reg [7:0] cirq_q;
  reg [7:0] crun_q;
  reg [7:0] cosc_q;
  reg [7:0] csrc_q;
  reg [3:0] rst_cnt_q;
  reg dph_q;
  reg dwr_q;
  reg [7:0] daddr_q;
  reg [31:0] rdata_d;
  reg [31:0] wd;
  reg [17:0] mcyc_d;
  reg [17:0] pcyc_d;

  // Wait code to cycle count: 2 to the power (code + 4), capped at 2 to the power 17 above code 13
  function [17:0] cgs_wait_cycles;
    input [4:0] code;
    begin
      if (code > 5'h0d)
        cgs_wait_cycles = 18'h20000;
      else
        cgs_wait_cycles = 18'h00010 << code;
    end
  endfunction

  // PLL wait code to cycle count: 2 to the power (code + 7), capped at 2 to the power 17 from code 10 up
  function [17:0] cgs_pll_wait_cycles;
    input [4:0] code;
    begin
      if (code >= `CGS_WAIT_PLL_CODE)
        cgs_pll_wait_cycles = `CGS_WAIT_PLL_CYC;
      else
        cgs_pll_wait_cycles = `CGS_WAIT_PLL_BASE << code;
    end
  endfunction

  // Divider field is already the divide exponent: 1 halves, 2 quarters
  function [3:0] cgs_div;
    input [3:0] field;
    begin
      cgs_div = field;
    end
  endfunction

  wire addr_ok = hsel && htrans[1] && hready;
  wire [7:0] a = daddr_q;
  wire wr = dph_q && dwr_q;
  wire cg_wr = wr && clockgen_write_enable_q;
  wire reset_busy = (rst_cnt_q != 4'h0);

  always @* begin
    wd = hwdata;
    mcyc_d = cgs_wait_cycles(mwait_q[4:0]);
    pcyc_d = cgs_pll_wait_cycles(pwait_q[4:0]);
    case (a)
      `CGS_A_PROT: rdata_d = {30'h0, lowpower_write_enable_q, clockgen_write_enable_q};
      `CGS_A_SDIV: rdata_d = sdiv_q;
      `CGS_A_SDIV2: rdata_d = {16'h0, sdiv2_q};
      `CGS_A_BPIN: rdata_d = {24'h0, bpin_q};
      `CGS_A_SSEL: rdata_d = {16'h0, ssel_q};
      `CGS_A_FOSC: rdata_d = {24'h0, fosc_q};
      `CGS_A_FPWR: rdata_d = {24'h0, fpwr_q};
      `CGS_A_MWAIT: rdata_d = {24'h0, mwait_q};
      `CGS_A_MOSC: rdata_d = {24'h0, mosc_q};
      `CGS_A_PWAIT: rdata_d = {24'h0, pwait_q};
      `CGS_A_PCFG: rdata_d = {16'h0, pcfg_q};
      `CGS_A_PRUN: rdata_d = {24'h0, prun_q};
      `CGS_A_SOSC: rdata_d = {24'h0, sosc_q};
      `CGS_A_CIRQ: rdata_d = {24'h0, cirq_q};
      // Reset bit reads 1 until the calendar reset completes
      `CGS_A_CRUN: rdata_d = {24'h0, crun_q[7:2], reset_busy, crun_q[0]};
      `CGS_A_COSC: rdata_d = {24'h0, cosc_q};
      `CGS_A_CSRC: rdata_d = {24'h0, csrc_q};
      `CGS_A_STAT: rdata_d = {28'h0, reset_busy, pll_run, main_osc_run, fast_osc_run};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      daddr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph_q <= addr_ok;
      dwr_q <= addr_ok && hwrite;
      if (addr_ok)
        daddr_q <= haddr[7:0];
      // Read data is registered, so a read costs one wait state
      if (dph_q && !dwr_q)
        hrdata <= rdata_d;
      hreadyout <= !(addr_ok && !hwrite);
      hresp <= 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clockgen_write_enable_q <= 1'b0;
      lowpower_write_enable_q <= 1'b0;
      sdiv_q <= `CGS_SDIV_RST;
      sdiv2_q <= `CGS_SDIV2_RST;
      bpin_q <= 8'h00;
      ssel_q <= 16'h0000;
      fosc_q <= 8'h01;
      fpwr_q <= 8'h00;
      mwait_q <= 8'h00;
      mosc_q <= 8'h01;
      pwait_q <= 8'h00;
      pcfg_q <= 16'h0000;
      prun_q <= 8'h01;
      sosc_q <= 8'h00;
      cirq_q <= 8'h00;
      crun_q <= 8'h00;
      cosc_q <= 8'h00;
      csrc_q <= 8'h00;
      rst_cnt_q <= 4'h0;
    end else begin
      if (wr && a == `CGS_A_PROT && wd[15:8] == `CGS_KEY) begin
        clockgen_write_enable_q <= wd[`CGS_PROT_CG];
        lowpower_write_enable_q <= wd[`CGS_PROT_LP];
      end
      if (cg_wr) begin
        case (a)
          `CGS_A_SDIV: sdiv_q <= wd;
          `CGS_A_SDIV2: sdiv2_q <= wd[15:0];
          `CGS_A_BPIN: bpin_q <= wd[7:0];
          `CGS_A_SSEL: ssel_q <= wd[15:0];
          `CGS_A_FOSC: fosc_q <= wd[7:0];
          `CGS_A_FPWR: fpwr_q <= wd[7:0];
          `CGS_A_MWAIT: mwait_q <= wd[7:0];
          `CGS_A_MOSC: mosc_q <= wd[7:0];
          `CGS_A_PWAIT: pwait_q <= wd[7:0];
          `CGS_A_PCFG: pcfg_q <= wd[15:0];
          `CGS_A_PRUN: prun_q <= wd[7:0];
          `CGS_A_SOSC: sosc_q <= wd[7:0];
          default: sosc_q <= sosc_q;
        endcase
      end
      // Calendar registers sit outside the clock-generation protection
      if (wr) begin
        case (a)
          `CGS_A_CIRQ: cirq_q <= wd[7:0];
          `CGS_A_CRUN: crun_q <= {wd[7:2], 1'b0, wd[0]};
          `CGS_A_COSC: cosc_q <= wd[7:0];
          `CGS_A_CSRC: csrc_q <= wd[7:0];
          default: csrc_q <= csrc_q;
        endcase
      end
      if (wr && a == `CGS_A_CRUN && wd[`CGS_CRUN_RESET])
        rst_cnt_q <= `CGS_RESET_CYC;
      else if (reset_busy)
        rst_cnt_q <= rst_cnt_q - 4'h1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      core_clock_div <= 4'h0;
      periph_clock_a_div <= 4'h0;
      periph_clock_b_div <= 4'h0;
      bus_clock_div <= 4'h0;
      flash_if_clock_div <= 4'h0;
      serial_bus_clock_div <= 4'h0;
      sdram_clock_pin_en <= 1'b0;
      bus_clock_pin_en <= 1'b0;
      bus_clock_pin_halved <= 1'b0;
      system_source_select <= `CGS_SRC_MAIN;
      fast_osc_run <= 1'b0;
      fast_osc_supply <= 1'b1;
      main_osc_run <= 1'b0;
      pll_run <= 1'b0;
      pll_input_divider <= 2'h0;
      pll_multiplier <= 6'h00;
      main_wait_cycles <= 18'h00010;
      pll_wait_cycles <= `CGS_WAIT_PLL_BASE;
      slow_osc_run <= 1'b0;
      slow_osc_drive <= 3'h0;
      calendar_main_source <= 1'b0;
      calendar_count_en <= 1'b0;
      calendar_reset_pulse <= 1'b0;
      alarm_irq_enable <= 1'b0;
      carry_irq_enable <= 1'b0;
      periodic_irq_enable <= 1'b0;
    end else begin
      core_clock_div <= cgs_div(sdiv_q[`CGS_SDIV_ICK+3:`CGS_SDIV_ICK]);
      periph_clock_a_div <= cgs_div(sdiv_q[`CGS_SDIV_PERIPH_A_DIVIDER+3:`CGS_SDIV_PERIPH_A_DIVIDER]);
      periph_clock_b_div <= cgs_div(sdiv_q[`CGS_SDIV_PERIPH_B_DIVIDER+3:`CGS_SDIV_PERIPH_B_DIVIDER]);
      bus_clock_div <= cgs_div(sdiv_q[`CGS_SDIV_BCK+3:`CGS_SDIV_BCK]);
      flash_if_clock_div <= cgs_div(sdiv_q[`CGS_SDIV_FCK+3:`CGS_SDIV_FCK]);
      serial_bus_clock_div <= cgs_div(sdiv2_q[`CGS_SDIV2_IEB+3:`CGS_SDIV2_IEB]);
      // Disabled pins are held high by the pad when the enable is low
      sdram_clock_pin_en <= !sdiv_q[`CGS_SDIV_SDRAM_CLOCK_PIN_STOP];
      bus_clock_pin_en <= !sdiv_q[`CGS_SDIV_BUS_CLOCK_PIN_STOP];
      bus_clock_pin_halved <= bpin_q[0];
      case (ssel_q[`CGS_SSEL_LSB+2:`CGS_SSEL_LSB])
        `CGS_SRC_FAST: system_source_select <= `CGS_SRC_FAST;
        `CGS_SRC_PLL: system_source_select <= `CGS_SRC_PLL;
        default: system_source_select <= `CGS_SRC_MAIN;
      endcase
      fast_osc_run <= !fosc_q[0] && !fpwr_q[0];
      fast_osc_supply <= !fpwr_q[0];
      main_osc_run <= !mosc_q[0];
      main_wait_cycles <= mcyc_d;
      pll_wait_cycles <= pcyc_d;
      pll_run <= !prun_q[0];
      pll_input_divider <= pcfg_q[1:0];
      pll_multiplier <= pcfg_q[`CGS_PCFG_MUL_LSB+5:`CGS_PCFG_MUL_LSB] + 6'h01;
      slow_osc_run <= !sosc_q[0] && cosc_q[`CGS_COSC_EN];
      slow_osc_drive <= cosc_q[`CGS_COSC_DRV+2:`CGS_COSC_DRV];
      calendar_main_source <= csrc_q[0];
      calendar_count_en <= crun_q[`CGS_CRUN_START] && !reset_busy;
      calendar_reset_pulse <= reset_busy;
      alarm_irq_enable <= cirq_q[3];
      carry_irq_enable <= cirq_q[1];
      periodic_irq_enable <= cirq_q[2];
    end
  end

endmodule // cgs_top

// File: verification/cgs_top_sva.sv
`timescale 1ns/100ps
module cgs_top_chk (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [2:0] system_source_select,
  input wire fast_osc_run,
  input wire fast_osc_supply,
  input wire calendar_reset_pulse,
  input wire calendar_count_en,
  input wire [3:0] core_clock_div
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = hsel && htrans[1] && hready;
  // Cycles since the last accepted write, saturating so it never wraps
  reg [2:0] idle_q;
  always @(posedge clk or posedge rst) begin
    if (rst)
      idle_q <= 3'h7;
    else if (acc && hwrite)
      idle_q <= 3'h0;
    else if (idle_q != 3'h7)
      idle_q <= idle_q + 3'h1;
  end
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("slave gave an error response");
  chk_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write was stalled");
  chk_reset_len: assert property ($rose(calendar_reset_pulse)
    |-> calendar_reset_pulse[*6] ##1 !calendar_reset_pulse)
    else $error("calendar reset length wrong");
  chk_halt_reset: assert property (calendar_reset_pulse |-> !calendar_count_en)
    else $error("counting during calendar reset");
  chk_src_code: assert property (system_source_select inside {3'h0, 3'h1, 3'h4})
    else $error("illegal source code");
  chk_fast_power: assert property (fast_osc_run |-> fast_osc_supply)
    else $error("fast oscillator runs unpowered");
  chk_div_cause: assert property ($changed(core_clock_div) |-> idle_q <= 3'h4)
    else $error("divider changed without a write");
endmodule // cgs_top_chk
bind cgs_top cgs_top_chk i_cgs_top_chk (.clk(clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .system_source_select(system_source_select),
  .fast_osc_run(fast_osc_run), .fast_osc_supply(fast_osc_supply),
  .calendar_reset_pulse(calendar_reset_pulse), .calendar_count_en(calendar_count_en),
  .core_clock_div(core_clock_div));

// File: verification/cgs_top_tb.sv
`timescale 1ns/100ps
`include "cgs_consts.vh"
module cgs_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire hready, hreadyout, hresp, sdram_clock_pin_en, bus_clock_pin_en, bus_clock_pin_halved;
  wire fast_osc_run, fast_osc_supply, main_osc_run, pll_run, slow_osc_run;
  wire calendar_main_source, calendar_count_en, calendar_reset_pulse;
  wire alarm_irq_enable, carry_irq_enable, periodic_irq_enable;
  wire [31:0] hrdata;
  wire [3:0] core_clock_div, periph_clock_a_div, periph_clock_b_div, bus_clock_div;
  wire [3:0] flash_if_clock_div, serial_bus_clock_div;
  wire [2:0] system_source_select, slow_osc_drive;
  wire [1:0] pll_input_divider;
  wire [5:0] pll_multiplier;
  wire [17:0] main_wait_cycles, pll_wait_cycles;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  cgs_top i_cgs_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_clock_div(core_clock_div),
    .periph_clock_a_div(periph_clock_a_div), .periph_clock_b_div(periph_clock_b_div),
    .bus_clock_div(bus_clock_div), .flash_if_clock_div(flash_if_clock_div),
    .serial_bus_clock_div(serial_bus_clock_div), .sdram_clock_pin_en(sdram_clock_pin_en),
    .bus_clock_pin_en(bus_clock_pin_en), .bus_clock_pin_halved(bus_clock_pin_halved),
    .system_source_select(system_source_select), .fast_osc_run(fast_osc_run),
    .fast_osc_supply(fast_osc_supply), .main_osc_run(main_osc_run), .pll_run(pll_run),
    .pll_input_divider(pll_input_divider), .pll_multiplier(pll_multiplier),
    .main_wait_cycles(main_wait_cycles), .pll_wait_cycles(pll_wait_cycles),
    .slow_osc_run(slow_osc_run), .slow_osc_drive(slow_osc_drive),
    .calendar_main_source(calendar_main_source), .calendar_count_en(calendar_count_en),
    .calendar_reset_pulse(calendar_reset_pulse), .alarm_irq_enable(alarm_irq_enable),
    .carry_irq_enable(carry_irq_enable), .periodic_irq_enable(periodic_irq_enable));
  always #5 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Entered right after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // Outputs update one edge after the data phase; checks wait one edge more
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_lock;
    wr(`CGS_A_SDIV, 32'h21c21211);
    chk(core_clock_div, 4'h0);
    wr(`CGS_A_PROT, 32'h00000003);
    wr(`CGS_A_SDIV, 32'h21c21211);
    chk(core_clock_div, 4'h0);
    wr(`CGS_A_PROT, 32'h0000a503);
    xfer(1'b0, `CGS_A_PROT, 32'h0);
    chk(rd, 32'h3);
  endtask
  task automatic t_divs;
    wr(`CGS_A_SDIV, 32'h21c21211);
    chk({core_clock_div, periph_clock_a_div, periph_clock_b_div}, 12'h112);
    chk({bus_clock_div, flash_if_clock_div}, 8'h22);
    chk({sdram_clock_pin_en, bus_clock_pin_en}, 2'b00);
    wr(`CGS_A_SDIV2, 32'h00000012);
    chk(serial_bus_clock_div, 4'h2);
    wr(`CGS_A_SDIV, 32'h21021211);
    chk({sdram_clock_pin_en, bus_clock_pin_en}, 2'b11);
    wr(`CGS_A_BPIN, 32'h1);
    chk(bus_clock_pin_halved, 1'b1);
    wr(`CGS_A_BPIN, 32'h0);
    chk(bus_clock_pin_halved, 1'b0);
  endtask
  task automatic t_src;
    logic [2:0] c [3] = '{3'h1, 3'h4, 3'h0};
    // Source settling time, scaled down to keep the run short
    repeat (10) @(posedge clk);
    foreach (c[i]) begin
      wr(`CGS_A_SSEL, {21'h0, c[i], 8'h0});
      chk(system_source_select, c[i]);
    end
  endtask
  task automatic t_osc;
    wr(`CGS_A_FOSC, 32'h0);
    chk(fast_osc_run, 1'b1);
    wr(`CGS_A_FOSC, 32'h1);
    chk(fast_osc_run, 1'b0);
    wr(`CGS_A_FPWR, 32'h1);
    chk(fast_osc_supply, 1'b0);
    wr(`CGS_A_MWAIT, 32'h0c);
    chk(main_wait_cycles, 18'h10000);
    wr(`CGS_A_MOSC, 32'h0);
    chk(main_osc_run, 1'b1);
    // Stabilisation wait after start, scaled down
    repeat (8) @(posedge clk);
    wr(`CGS_A_PWAIT, 32'h0a);
    chk(pll_wait_cycles, 18'h20000);
    wr(`CGS_A_PCFG, 32'h0f00);
    chk({pll_input_divider, pll_multiplier}, {2'h0, 6'h10});
    wr(`CGS_A_PRUN, 32'h0);
    chk(pll_run, 1'b1);
  endtask
  task automatic t_slow;
    wr(`CGS_A_SOSC, 32'h0);
    wr(`CGS_A_COSC, 32'h0d);
    chk({slow_osc_run, slow_osc_drive}, {1'b1, 3'h6});
    wr(`CGS_A_COSC, 32'h0c);
    chk(slow_osc_run, 1'b0);
    repeat (5) @(posedge clk);
    wr(`CGS_A_COSC, 32'h03);
    chk({slow_osc_run, slow_osc_drive}, {1'b1, 3'h1});
    wr(`CGS_A_SOSC, 32'h1);
    chk(slow_osc_run, 1'b0);
    repeat (6) @(posedge clk);
  endtask
  task automatic t_cal;
    wr(`CGS_A_CSRC, 32'h1);
    chk(calendar_main_source, 1'b1);
    wr(`CGS_A_CSRC, 32'h0);
    chk(calendar_main_source, 1'b0);
    wr(`CGS_A_CRUN, 32'h1);
    chk(calendar_count_en, 1'b1);
    wr(`CGS_A_CRUN, 32'h1 & 32'h7e);
    chk(calendar_count_en, 1'b0);
    wr(`CGS_A_CIRQ, 32'h0a);
    chk({alarm_irq_enable, carry_irq_enable, periodic_irq_enable}, 3'h6);
    wr(`CGS_A_CIRQ, 32'h0);
    chk({alarm_irq_enable, carry_irq_enable, periodic_irq_enable}, 3'h0);
    // Start is written set along with the reset, so counting must be held off only by the reset
    xfer(1'b1, `CGS_A_CRUN, 32'h3);
    xfer(1'b0, `CGS_A_STAT, 32'h0);
    chk(rd[3], 1'b1);
    chk(calendar_count_en, 1'b0);
    while (rd[3] !== 1'b0) xfer(1'b0, `CGS_A_STAT, 32'h0);
    chk(calendar_reset_pulse, 1'b0);
    chk(calendar_count_en, 1'b1);
  endtask
  task automatic t_relock;
    wr(`CGS_A_PROT, 32'h0000a500);
    xfer(1'b0, `CGS_A_PROT, 32'h0);
    chk(rd, 32'h0);
    wr(`CGS_A_SDIV, 32'h0);
    chk(core_clock_div, 4'h1);
    xfer(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk({hreadyout, core_clock_div, system_source_select}, {1'b1, 4'h0, 3'h0});
    t_lock();
    t_divs();
    t_src();
    t_osc();
    t_slow();
    t_cal();
    t_relock();
    complete_run();
  end
endmodule // cgs_top_tb
